//--- hw/nfam_pkg.sv
package nfam_pkg;

  // Lamp blink timing
  localparam int unsigned CLK_PERIOD_NS = 5;
  localparam int unsigned LAMP_HALF_MS = 500;
  localparam int unsigned LAMP_HALF_CYC = LAMP_HALF_MS * 1000000 / CLK_PERIOD_NS;

  // Alarm numbers and selectors
  localparam logic [15:0] NUM_CLEAR = 16'h0000;
  localparam logic [15:0] ALARM_MAX = 16'h01FF;
  localparam logic [15:0] SEL_ONE_MIN = 16'h0001;
  localparam logic [15:0] SEL_ONE_MAX = 16'h01FF;
  localparam logic [15:0] SEL_ALL = 16'hFFFF;
  localparam logic [15:0] USER_CODE_BASE = 16'h4100;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  // Executed-alarm flag array, bit n belongs to alarm n
  localparam int unsigned FLAG_N = 512;
  localparam int unsigned IDX_W = 9;

  // Simulated system error codes and their slots
  localparam logic [15:0] SYS_ANALOG = 16'h008A;
  localparam logic [15:0] SYS_SETUP = 16'h009B;
  localparam logic [15:0] SYS_OPTION = 16'h00D1;
  localparam logic [15:0] SYS_BATTERY = 16'h00F7;
  localparam logic [15:0] OPT_SLOT = 16'h0001;
  localparam int unsigned SYS_N = 4;
  localparam logic [1:0] SK_ANALOG = 2'h0;
  localparam logic [1:0] SK_SETUP = 2'h1;
  localparam logic [1:0] SK_OPTION = 2'h2;
  localparam logic [1:0] SK_BATTERY = 2'h3;

  // Error log ring
  localparam int unsigned LOG_DEPTH = 20;
  localparam int unsigned LOG_AW = 5;
  localparam int unsigned CODE_W = 16;
  localparam int unsigned TIME_W = 32;
  localparam int unsigned LOG_W = CODE_W + TIME_W;
  localparam logic [4:0] LOG_LAST = 5'h13;
  localparam logic [4:0] LOG_FULL = 5'h14;

  // Message
  localparam int unsigned MSG_CHARS = 16;
  localparam int unsigned MSG_W = 128;
  localparam logic [7:0] MSG_END = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_RAISE_USER = 3'h1,
    OP_RAISE_SYS = 3'h3,
    OP_CLR_ONE = 3'h2,
    OP_CLR_ALL = 3'h6,
    OP_CLR_TOP = 3'h7,
    OP_BAD = 3'h5
  } nfam_op_t;

  function automatic logic sys_known(input logic [15:0] code);
    return (code == SYS_ANALOG) || (code == SYS_SETUP) || (code == SYS_OPTION) || (code == SYS_BATTERY);
  endfunction

  function automatic logic sys_valid(input logic [15:0] code, input logic [15:0] detail);
    return sys_known(code) && ((code != SYS_OPTION) || (detail == OPT_SLOT));
  endfunction

  function automatic logic [1:0] sys_kind_of(input logic [15:0] code);
    case (code)
      SYS_SETUP: return SK_SETUP;
      SYS_OPTION: return SK_OPTION;
      SYS_BATTERY: return SK_BATTERY;
      default: return SK_ANALOG;
    endcase
  endfunction

  function automatic logic [15:0] sys_code_of(input logic [1:0] kind);
    case (kind)
      SK_SETUP: return SYS_SETUP;
      SK_OPTION: return SYS_OPTION;
      SK_BATTERY: return SYS_BATTERY;
      default: return SYS_ANALOG;
    endcase
  endfunction

endpackage

//--- hw/nfam_if.sv
`timescale 1ns/10ps
`default_nettype none

interface nfam_flag_if;
  logic set;
  logic clr;
  logic clr_all;
  logic [nfam_pkg::IDX_W-1:0] idx;
  logic [nfam_pkg::FLAG_N-1:0] flags;
  logic any;
  logic [nfam_pkg::IDX_W-1:0] lowest;
  logic [nfam_pkg::IDX_W-1:0] highest;
  modport ctrl (output set, output clr, output clr_all, output idx,
                input flags, input any, input lowest, input highest);
  modport bank (input set, input clr, input clr_all, input idx,
                output flags, output any, output lowest, output highest);
endinterface

interface nfam_log_if;
  logic we;
  logic [nfam_pkg::LOG_AW-1:0] waddr;
  logic [nfam_pkg::LOG_W-1:0] wdata;
  logic [nfam_pkg::LOG_AW-1:0] raddr;
  logic [nfam_pkg::LOG_W-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

//--- hw/nfam_flag_bank.sv
`timescale 1ns/10ps
`default_nettype none

module nfam_flag_bank
  import nfam_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  nfam_flag_if.bank fif
);

  logic [FLAG_N-1:0] flags_q;
  logic [IDX_W-1:0] lo;
  logic [IDX_W-1:0] hi;

  always_ff @(posedge clk_sys)
  begin
    if (srst || fif.clr_all)
      flags_q <= '0;
    else
    begin
      if (fif.set)
        flags_q[fif.idx] <= 1'b1;
      if (fif.clr)
        flags_q[fif.idx] <= 1'b0;
    end
  end

  // Lowest and highest pending alarm numbers; bit 0 is never set
  always_comb
  begin
    lo = '0;
    hi = '0;
    for (int i = FLAG_N - 1; i >= 1; i--)
      if (flags_q[i])
        lo = IDX_W'(i);
    for (int i = 1; i < FLAG_N; i++)
      if (flags_q[i])
        hi = IDX_W'(i);
  end

  assign fif.flags = flags_q;
  assign fif.any = |flags_q;
  assign fif.lowest = lo;
  assign fif.highest = hi;

endmodule

`default_nettype wire

//--- hw/nfam_log_mem.sv
`timescale 1ns/10ps
`default_nettype none

module nfam_log_mem
  import nfam_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  nfam_log_if.mem lif
);

  logic [LOG_W-1:0] mem_q [LOG_DEPTH];
  logic [LOG_W-1:0] rdata_q;

  always_ff @(posedge clk_sys)
  begin
    if (lif.we)
      mem_q[lif.waddr] <= lif.wdata;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata_q <= '0;
    else
      rdata_q <= mem_q[lif.raddr];
  end

  assign lif.rdata = rdata_q;

endmodule

`default_nettype wire

//--- hw/nfam_alarm_mgr.sv
// Functional notes
// - Selector 1..1FF clears that user alarm
// - Selector FFFF clears every non-fatal error
// - Other selector clears most serious, lowest user
// - User alarm sets summary flag, keeps running
// - User alarm sets its executed-alarm flag
// - User alarm code is 4100 plus number
// - User alarm logged with code and time
// - Any non-fatal error flashes fault lamp
// - Word message: 16 chars, MSB first, null-ended
// - Shown message follows live message words
// - Error code word holds highest code
// - Dummy number raises logged simulated system error
// - Simulated error leaves user flags alone
// - Repeated simulated errors each raise distinctly
// - Known simulated codes and detail checks
// - Simulated error cleared by fix strobe, clear all or clear top
// - Suppression skips only user alarm logging
// - Suppressed alarms still set flags and code
// - Clear one drops its flag and summary
// - Clear top updates code and user flags
// - Simulated option error sets option flag
// - Bad number or simulated operands flag error
// - Log keeps only newest 20 entries
`timescale 1ns/10ps
`default_nettype none

module nfam_alarm_mgr
  import nfam_pkg::*;
#(
  parameter int unsigned LAMP_HALF = LAMP_HALF_CYC
)
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic instr_strobe,
  input wire logic [15:0] alarm_num,
  input wire logic sel_is_word,
  input wire logic [15:0] sel_value,
  input wire logic [15:0] op_word0,
  input wire logic [15:0] op_word1,
  input wire logic [MSG_W-1:0] msg_words,
  input wire logic [15:0] dummy_num,
  input wire logic log_suppress,
  input wire logic [TIME_W-1:0] time_now,
  input wire logic sys_fix_strobe,
  input wire logic [15:0] sys_fix_code,
  input wire logic [LOG_AW-1:0] log_rd_age,
  output logic instr_error_flag,
  output logic user_alarm_flag,
  output logic [FLAG_N-1:0] exec_flags,
  output logic [15:0] err_code,
  output logic [15:0] err_detail,
  output logic [SYS_N-1:0] sys_err_active,
  output logic opt_board_err,
  output logic fault_lamp,
  output logic fault_lamp_flash,
  output logic msg_valid,
  output logic [MSG_W-1:0] msg_chars,
  output logic [LOG_AW-1:0] msg_len,
  output logic [LOG_AW-1:0] log_count,
  output logic [CODE_W-1:0] log_rd_code,
  output logic [TIME_W-1:0] log_rd_time
);

  nfam_flag_if fif ();
  nfam_log_if lif ();

  nfam_flag_bank u_bank (
    .clk_sys(clk_sys),
    .srst(srst),
    .fif(fif)
  );

  nfam_log_mem u_log (
    .clk_sys(clk_sys),
    .srst(srst),
    .lif(lif)
  );

  function automatic logic [1:0] hi_sys(input logic [SYS_N-1:0] act);
    logic [1:0] k;
    k = SK_ANALOG;
    for (int i = 0; i < SYS_N; i++)
      if (act[i])
        k = 2'(i);
    return k;
  endfunction

  function automatic logic [LOG_AW-1:0] log_slot(input logic [LOG_AW-1:0] wr, input logic [LOG_AW-1:0] age);
    logic [5:0] t;
    logic [LOG_AW-1:0] a;
    a = (age > LOG_LAST) ? LOG_LAST : age;
    t = {1'b0, wr} + 6'(LOG_DEPTH) - 6'h01 - {1'b0, a};
    if (t >= 6'(LOG_DEPTH))
      t = t - 6'(LOG_DEPTH);
    return t[LOG_AW-1:0];
  endfunction

  nfam_op_t op;
  logic instr_error_flag_q;
  logic user_alarm_flag_q;
  logic [15:0] err_code_q;
  logic [15:0] sys_detail_q;
  logic [SYS_N-1:0] sys_act_q;
  logic [SYS_N-1:0] sys_set;
  logic [SYS_N-1:0] sys_clr;
  logic clr_top_user;
  logic clr_top_sys;
  logic [15:0] user_code;
  logic [15:0] sys_code;
  logic [15:0] log_code;
  logic log_we;
  logic [LOG_AW-1:0] wr_ptr_q;
  logic [LOG_AW-1:0] log_count_q;
  logic msg_active_q;
  logic [IDX_W-1:0] msg_num_q;
  logic [MSG_W-1:0] msg_d;
  logic [LOG_AW-1:0] len_d;
  logic [MSG_W-1:0] msg_chars_q;
  logic [LOG_AW-1:0] msg_len_q;
  logic lamp_flash_q;
  logic lamp_q;
  logic [31:0] lamp_cnt_q;

  // Instruction decode, valid only in the strobe cycle
  always_comb
  begin
    op = OP_NONE;
    if (instr_strobe)
    begin
      if (alarm_num > ALARM_MAX)
        op = OP_BAD;
      else if (alarm_num == NUM_CLEAR)
      begin
        if (sel_is_word)
          op = OP_CLR_TOP;
        else if (sel_value == SEL_ALL)
          op = OP_CLR_ALL;
        else if (sel_value >= SEL_ONE_MIN && sel_value <= SEL_ONE_MAX)
          op = OP_CLR_ONE;
        else
          op = OP_CLR_TOP;
      end
      else if (alarm_num == dummy_num)
        op = sys_valid(op_word0, op_word1) ? OP_RAISE_SYS : OP_BAD;
      else
        op = OP_RAISE_USER;
    end
  end

  // User alarms outrank every simulated code, so clear top picks users first
  assign clr_top_user = (op == OP_CLR_TOP) && fif.any;
  assign clr_top_sys = (op == OP_CLR_TOP) && !fif.any && (|sys_act_q);

  assign fif.set = (op == OP_RAISE_USER);
  assign fif.clr = (op == OP_CLR_ONE) || clr_top_user;
  assign fif.clr_all = (op == OP_CLR_ALL);
  assign fif.idx = (op == OP_CLR_ONE) ? sel_value[IDX_W-1:0] :
                   clr_top_user ? fif.lowest : alarm_num[IDX_W-1:0];

  always_comb
  begin
    sys_set = '0;
    sys_clr = '0;
    if (op == OP_RAISE_SYS)
      sys_set[sys_kind_of(op_word0)] = 1'b1;
    if (sys_fix_strobe && sys_known(sys_fix_code))
      sys_clr[sys_kind_of(sys_fix_code)] = 1'b1;
    if (clr_top_sys)
      sys_clr[hi_sys(sys_act_q)] = 1'b1;
  end

  // Set wins over any clear arriving in the same cycle
  always_ff @(posedge clk_sys)
  begin
    if (srst || op == OP_CLR_ALL)
      sys_act_q <= '0;
    else
      sys_act_q <= (sys_act_q & ~sys_clr) | sys_set;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      sys_detail_q <= '0;
    else if (op == OP_RAISE_SYS)
      sys_detail_q <= op_word1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      instr_error_flag_q <= 1'b0;
    else if (instr_strobe)
      instr_error_flag_q <= (op == OP_BAD);
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      user_alarm_flag_q <= 1'b0;
    else if (op == OP_RAISE_USER)
      user_alarm_flag_q <= 1'b1;
    else if (op == OP_CLR_ONE || op == OP_CLR_ALL || clr_top_user)
      user_alarm_flag_q <= 1'b0;
  end

  // Error code word follows the highest pending code
  assign user_code = fif.any ? (USER_CODE_BASE + {7'h00, fif.highest}) : CODE_NONE;
  assign sys_code = (|sys_act_q) ? sys_code_of(hi_sys(sys_act_q)) : CODE_NONE;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      err_code_q <= CODE_NONE;
    else
      err_code_q <= (user_code > sys_code) ? user_code : sys_code;
  end

  // Error log ring, oldest entry overwritten once full
  assign log_we = ((op == OP_RAISE_USER) && !log_suppress) || (op == OP_RAISE_SYS);
  assign log_code = (op == OP_RAISE_SYS) ? op_word0 : (USER_CODE_BASE + alarm_num);
  assign lif.we = log_we;
  assign lif.waddr = wr_ptr_q;
  assign lif.wdata = {log_code, time_now};
  assign lif.raddr = log_slot(wr_ptr_q, log_rd_age);

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      wr_ptr_q <= '0;
    else if (log_we)
      wr_ptr_q <= (wr_ptr_q == LOG_LAST) ? '0 : wr_ptr_q + 5'h01;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      log_count_q <= '0;
    else if (log_we && log_count_q != LOG_FULL)
      log_count_q <= log_count_q + 5'h01;
  end

  // Message registration; characters are refreshed from the live words
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      msg_active_q <= 1'b0;
      msg_num_q <= '0;
    end
    else if (op == OP_RAISE_USER && sel_is_word)
    begin
      msg_active_q <= 1'b1;
      msg_num_q <= alarm_num[IDX_W-1:0];
    end
    else if (op == OP_CLR_ALL || ((op == OP_CLR_ONE || clr_top_user) && fif.idx == msg_num_q))
      msg_active_q <= 1'b0;
  end

  always_comb
  begin
    logic stop;
    stop = 1'b0;
    msg_d = '0;
    len_d = '0;
    for (int i = 0; i < MSG_CHARS; i++)
    begin
      if (!stop)
      begin
        if (msg_words[MSG_W-1-8*i -: 8] == MSG_END)
          stop = 1'b1;
        else
        begin
          msg_d[MSG_W-1-8*i -: 8] = msg_words[MSG_W-1-8*i -: 8];
          len_d = len_d + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst || !msg_active_q)
    begin
      msg_chars_q <= '0;
      msg_len_q <= '0;
    end
    else
    begin
      msg_chars_q <= msg_d;
      msg_len_q <= len_d;
    end
  end

  // Fault lamp blinks while any non-fatal error is pending
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      lamp_flash_q <= 1'b0;
    else
      lamp_flash_q <= fif.any || (|sys_act_q);
  end

  always_ff @(posedge clk_sys)
  begin
    // Idle count sits at the wrap value so the lamp lights on the first flashing edge
    if (srst || !lamp_flash_q)
    begin
      lamp_cnt_q <= 32'(LAMP_HALF - 1);
      lamp_q <= 1'b0;
    end
    else if (lamp_cnt_q == 32'(LAMP_HALF - 1))
    begin
      lamp_cnt_q <= '0;
      lamp_q <= ~lamp_q;
    end
    else
      lamp_cnt_q <= lamp_cnt_q + 32'h00000001;
  end

  assign instr_error_flag = instr_error_flag_q;
  assign user_alarm_flag = user_alarm_flag_q;
  assign exec_flags = fif.flags;
  assign err_code = err_code_q;
  assign err_detail = sys_detail_q;
  assign sys_err_active = sys_act_q;
  assign opt_board_err = sys_act_q[SK_OPTION];
  assign fault_lamp = lamp_q;
  assign fault_lamp_flash = lamp_flash_q;
  assign msg_valid = msg_active_q;
  assign msg_chars = msg_chars_q;
  assign msg_len = msg_len_q;
  assign log_count = log_count_q;
  assign log_rd_code = lif.rdata[LOG_W-1:TIME_W];
  assign log_rd_time = lif.rdata[TIME_W-1:0];

  // Checking helpers
  logic [IDX_W-1:0] ast_idx_q;
  logic [7:0] ast_msg0_q;
  always_ff @(posedge clk_sys)
  begin
    ast_idx_q <= fif.idx;
    ast_msg0_q <= msg_words[MSG_W-1 -: 8];
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  AST_CLR_ONE: assert property ((op == OP_CLR_ONE) |=> !fif.flags[ast_idx_q] && !user_alarm_flag_q)
    else $error("clear one left flag or summary on");
  AST_CLR_ALL: assert property ((op == OP_CLR_ALL) |=> (fif.flags == '0) && (sys_act_q == '0) && !user_alarm_flag_q
    ##1 (err_code_q == CODE_NONE))
    else $error("clear all left an error pending");
  AST_CLR_TOP: assert property (clr_top_user |=> !fif.flags[ast_idx_q] && !user_alarm_flag_q)
    else $error("clear top missed lowest user alarm");
  AST_RAISE: assert property ((op == OP_RAISE_USER) |=> user_alarm_flag_q && fif.flags[ast_idx_q])
    else $error("user alarm flags not set");
  AST_CODE: assert property ((op == OP_RAISE_USER) |=> ##1 (err_code_q >= $past(log_code, 2)))
    else $error("error code below raised user code");
  AST_LOG_SUPP: assert property ((op == OP_RAISE_USER) && log_suppress |=> (wr_ptr_q == $past(wr_ptr_q))
    && user_alarm_flag_q)
    else $error("suppressed user alarm was logged");
  AST_LOG_SYS: assert property ((op == OP_RAISE_SYS) |=> (wr_ptr_q != $past(wr_ptr_q))
    && (fif.flags == $past(fif.flags)))
    else $error("simulated error not logged or touched flags");
  AST_OPT: assert property ((op == OP_RAISE_SYS) && (op_word0 == SYS_OPTION) |=> opt_board_err)
    else $error("option board flag not set");
  AST_BAD: assert property (instr_strobe && (alarm_num > ALARM_MAX) |=> instr_error_flag_q)
    else $error("bad alarm number not flagged");
  AST_LOG_FULL: assert property ((log_count_q == LOG_FULL) |=> (log_count_q == LOG_FULL))
    else $error("log count left full state");
  AST_LAMP: assert property ((op == OP_RAISE_USER || op == OP_RAISE_SYS) |=> ##1 lamp_flash_q)
    else $error("lamp not flashing after alarm");
  AST_MSG: assert property (msg_active_q && (msg_words[MSG_W-1 -: 8] != MSG_END)
    |=> (msg_chars_q[MSG_W-1 -: 8] == ast_msg0_q))
    else $error("message does not follow its words");

  COV_USER: cover property ((op == OP_RAISE_USER) && sel_is_word);
  COV_SYS: cover property (op == OP_RAISE_SYS);
  COV_TOP_SYS: cover property (clr_top_sys);
  COV_WRAP: cover property ((log_count_q == LOG_FULL) && log_we);

endmodule

`default_nettype wire

//--- verif/nfam_prog.sv
`timescale 1ns/10ps
`default_nettype none

module nfam_prog
  import nfam_pkg::*;
(
  input wire logic clk_sys,
  output logic instr_strobe,
  output logic [15:0] alarm_num,
  output logic sel_is_word,
  output logic [15:0] sel_value,
  output logic [15:0] op_word0,
  output logic [15:0] op_word1,
  output logic [MSG_W-1:0] msg_words
);
  initial
  begin
    instr_strobe = 1'b0;
    alarm_num = 16'h0000;
    sel_is_word = 1'b0;
    sel_value = 16'h0000;
    op_word0 = 16'h0000;
    op_word1 = 16'h0000;
    msg_words = '0;
  end

  // One-cycle strobe with stable operands, which are scrambled once it is over
  task automatic instr(input logic [15:0] n, input logic w, input logic [15:0] s, input logic [15:0] d);
    @(negedge clk_sys);
    instr_strobe = 1'b1;
    alarm_num = n;
    sel_is_word = w;
    sel_value = s;
    op_word0 = s;
    op_word1 = d;
    @(negedge clk_sys);
    instr_strobe = 1'b0;
    alarm_num = ~n;
    sel_is_word = ~w;
    sel_value = ~s;
    op_word0 = ~s;
    op_word1 = ~d;
  endtask

  task automatic set_msg(input logic [MSG_W-1:0] m);
    @(negedge clk_sys);
    msg_words = m;
  endtask
endmodule

`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  import nfam_pkg::*;
  localparam int unsigned LH = 4;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic instr_strobe, sel_is_word, log_suppress, sys_fix_strobe;
  logic [15:0] alarm_num, sel_value, op_word0, op_word1, dummy_num, sys_fix_code;
  logic [MSG_W-1:0] msg_words, msg_chars;
  logic [TIME_W-1:0] time_now = 32'h0000_0000;
  logic [TIME_W-1:0] t_last, log_rd_time;
  logic [LOG_AW-1:0] log_rd_age, msg_len, log_count;
  logic instr_error_flag, user_alarm_flag, opt_board_err, fault_lamp, fault_lamp_flash, msg_valid;
  logic [FLAG_N-1:0] exec_flags, m_flags;
  logic [15:0] err_code, err_detail, log_rd_code;
  logic [SYS_N-1:0] sys_err_active, m_sys;
  logic m_sum, m_err;
  logic [47:0] m_q[$];
  logic [15:0] sys_tab [4] = '{16'h008A, 16'h009B, 16'h00D1, 16'h00F7};
  int err_total = 0;
  int samples_checked = 0;

  always #2.5 clk_sys = ~clk_sys;
  always @(negedge clk_sys) time_now <= time_now + 32'($urandom % 7) + 32'h1;
  always @(posedge clk_sys) if (instr_strobe) t_last <= time_now;

  nfam_prog i_nfam_prog (.clk_sys, .instr_strobe, .alarm_num, .sel_is_word, .sel_value, .op_word0, .op_word1,
    .msg_words);
  nfam_alarm_mgr #(.LAMP_HALF(LH)) i_nfam_alarm_mgr (.clk_sys, .srst, .instr_strobe, .alarm_num, .sel_is_word,
    .sel_value, .op_word0, .op_word1, .msg_words, .dummy_num, .log_suppress, .time_now, .sys_fix_strobe,
    .sys_fix_code, .log_rd_age, .instr_error_flag, .user_alarm_flag, .exec_flags, .err_code, .err_detail,
    .sys_err_active, .opt_board_err, .fault_lamp, .fault_lamp_flash, .msg_valid, .msg_chars, .msg_len,
    .log_count, .log_rd_code, .log_rd_time);

  function automatic logic [15:0] top_code();
    for (int i = 511; i > 0; i--)
      if (m_flags[i]) return 16'h4100 + 16'(i);
    for (int i = 3; i >= 0; i--)
      if (m_sys[i]) return sys_tab[i];
    return 16'h0000;
  endfunction

  task automatic chk(input logic [511:0] seen, input logic [511:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic check_state();
    chk(exec_flags, m_flags);
    chk(user_alarm_flag, m_sum);
    chk(sys_err_active, m_sys);
    chk(opt_board_err, m_sys[2]);
    chk(err_code, top_code());
    chk(instr_error_flag, m_err);
    chk(log_count, (m_q.size() > 20) ? 20 : m_q.size());
    chk(fault_lamp_flash, |{m_flags, m_sys});
  endtask

  task automatic read_log(input int age);
    @(negedge clk_sys);
    log_rd_age = 5'(age);
    @(negedge clk_sys);
    chk(log_rd_code, m_q[age][47:32]);
    chk(log_rd_time, m_q[age][31:0]);
  endtask

  task automatic op(input logic [15:0] n, input logic w, input logic [15:0] s, input logic [15:0] d);
    i_nfam_prog.instr(n, w, s, d);
    repeat (3) @(negedge clk_sys);
    m_err = 1'b0;
  endtask

  task automatic user(input logic [15:0] n, input logic w);
    op(n, w, 16'h0000, 16'h0000);
    m_flags[n[8:0]] = 1'b1;
    m_sum = 1'b1;
    if (!log_suppress)
      m_q.push_front({16'h4100 + n, t_last});
    check_state();
    if (!log_suppress)
      read_log(0);
  endtask

  task automatic sys(input int k, input logic [15:0] d);
    op(dummy_num, 1'b0, sys_tab[k], d);
    m_sys[k] = 1'b1;
    m_q.push_front({sys_tab[k], t_last});
    check_state();
    chk(err_detail, d);
    read_log(0);
  endtask

  task automatic clr_top(input logic [15:0] s, input logic w);
    int i;
    int k;
    op(16'h0000, w, s, 16'h0000);
    i = 1;
    while (i < 512 && m_flags[i] !== 1'b1)
      i++;
    if (i < 512)
    begin
      m_flags[i] = 1'b0;
      m_sum = 1'b0;
    end
    else
    begin
      k = 3;
      while (k > 0 && !m_sys[k])
        k--;
      m_sys[k] = 1'b0;
    end
    check_state();
  endtask

  task automatic fix(input logic [15:0] c);
    @(negedge clk_sys);
    sys_fix_strobe = 1'b1;
    sys_fix_code = c;
    @(negedge clk_sys);
    sys_fix_strobe = 1'b0;
    sys_fix_code = ~c;
    repeat (2) @(negedge clk_sys);
  endtask

  // Limit of 20000 cycles is far above the expected run length of a few hundred cycles
  initial
  begin
    #100000;
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end

  initial
  begin
    int k;
    logic l;
    logic [15:0] n;
    logic [127:0] m;
    log_suppress = 1'b0;
    sys_fix_strobe = 1'b0;
    sys_fix_code = 16'h0000;
    dummy_num = 16'h000A;
    log_rd_age = 5'h00;
    m_flags = '0;
    m_sys = '0;
    m_sum = 1'b0;
    m_err = 1'b0;
    void'($urandom(32'h37c0));
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys);
    srst = 1'b0;
    @(negedge clk_sys);
    check_state();
    $display("test reset done");
    user(16'h001F, 1'b0);
    user(16'h01FF, 1'b0);
    repeat (6)
    begin
      n = 16'(1 + $urandom % 511);
      if (n == dummy_num)
        n = 16'h0001;
      user(n, 1'b0);
    end
    k = 0;
    l = fault_lamp;
    repeat (16)
    begin
      @(negedge clk_sys);
      if (fault_lamp !== l)
        k++;
      l = fault_lamp;
    end
    chk(k, 4);
    $display("test raise done");
    log_suppress = 1'b1;
    user(16'h0005, 1'b0);
    log_suppress = 1'b0;
    op(16'h0000, 1'b0, 16'h01FF, 16'h0000);
    m_flags[511] = 1'b0;
    m_sum = 1'b0;
    check_state();
    op(16'h0000, 1'b0, 16'h001F, 16'h0000);
    m_flags[31] = 1'b0;
    check_state();
    clr_top(16'h0200, 1'b0);
    clr_top(16'hFFFE, 1'b0);
    clr_top(16'h1234, 1'b1);
    $display("test clear done");
    log_suppress = 1'b1;
    for (int i = 0; i < 4; i++)
      sys(i, (i == 2) ? 16'h0001 : 16'($urandom));
    sys(3, 16'($urandom));
    log_suppress = 1'b0;
    op(dummy_num, 1'b0, 16'h00D1, 16'h0002);
    m_err = 1'b1;
    check_state();
    op(16'h0258, 1'b0, 16'h0000, 16'h0000);
    m_err = 1'b1;
    check_state();
    op(dummy_num, 1'b0, 16'h1234, 16'h0000);
    m_err = 1'b1;
    check_state();
    fix(16'h009B);
    m_sys[1] = 1'b0;
    check_state();
    op(16'h0000, 1'b0, 16'hFFFF, 16'h0000);
    m_flags = '0;
    m_sys = '0;
    m_sum = 1'b0;
    check_state();
    sys(0, 16'($urandom));
    sys(3, 16'($urandom));
    clr_top(16'h0300, 1'b0);
    op(16'h0000, 1'b0, 16'hFFFF, 16'h0000);
    m_sys = '0;
    check_state();
    $display("test system done");
    m = {$urandom, $urandom, $urandom, $urandom} | {16{8'h01}};
    m[87:80] = 8'h00;
    i_nfam_prog.set_msg(m);
    user(16'h0007, 1'b1);
    chk(msg_valid, 1'b1);
    chk(msg_len, 5'h05);
    chk(msg_chars, {m[127:88], 88'h0});
    m = {$urandom, $urandom, $urandom, $urandom} | {16{8'h01}};
    i_nfam_prog.set_msg(m);
    repeat (3) @(negedge clk_sys);
    chk(msg_chars, m);
    $display("test message done");
    for (int i = 0; i < 22; i++)
      user(16'(100 + i), 1'b0);
    read_log(19);
    $display("test log ring done");
    end_of_test();
  end
endmodule

`default_nettype wire
